// ===== inc/edoc_defines.svh
`ifndef EDOC_DEFINES_SVH
`define EDOC_DEFINES_SVH

// Clock period in ns
`define EDOC_CLK_NS 50
// Timing figures in ns (slowest speed grade)
`define EDOC_RANDOM_CYCLE_NS 130
`define EDOC_PAGE_CYCLE_NS 30
`define EDOC_PAGE_WIDTH_MAX_NS 125000
`define EDOC_RAS_MIN_NS 70
`define EDOC_RAS_PRECHARGE_NS 50
`define EDOC_CAS_MIN_NS 12
`define EDOC_CAS_PRECHARGE_NS 10
`define EDOC_REFRESH_COLUMN_SETUP_NS 5
`define EDOC_REFRESH_COLUMN_HOLD_NS 12
`define EDOC_REFRESH_WRITE_SETUP_NS 10
`define EDOC_REFRESH_WRITE_HOLD_NS 10
`define EDOC_WRITE_DISABLE_PULSE_NS 12
`define EDOC_ENABLE_HIGH_PULSE_NS 10
`define EDOC_RAS_TO_CAS_NS 14
// Refresh period in us, wake pause in us
`define EDOC_REFRESH_PERIOD_US 64000
`define EDOC_INIT_PAUSE_US 100
`define EDOC_REFRESH_CYCLES 4096
`define EDOC_WAKE_CYCLES 8
// Cycle counts, least times rounded up
`define EDOC_CYC_UP(ns) (((ns) + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_CYC_MIN(ns) ((`EDOC_CYC_UP(ns) < 1) ? 1 : `EDOC_CYC_UP(ns))
`define EDOC_PAGE_MAX_CYC ((`EDOC_PAGE_WIDTH_MAX_NS) / `EDOC_CLK_NS)
`define EDOC_INIT_PAUSE_CYC (`EDOC_INIT_PAUSE_US * 1000 / `EDOC_CLK_NS)
`define EDOC_REFRESH_INTERVAL_CYC \
  ((`EDOC_REFRESH_PERIOD_US * 1000 / `EDOC_CLK_NS) / `EDOC_REFRESH_CYCLES)

`endif

// ===== inc/edoc_pkg.sv
package edoc_pkg;
  typedef enum logic [1:0] {EDOC_OP_READ, EDOC_OP_WRITE, EDOC_OP_REFRESH_ROW} edoc_op_e;
  typedef logic [15:0] edoc_count_t;
endpackage

// ===== inc/edoc_tick_if.sv
`timescale 1ns/100ps
interface edoc_tick_if;
  logic due;
  logic taken;
  logic wakeNeeded;
  modport timer (output due, output wakeNeeded, input taken);
  modport user (input due, input wakeNeeded, output taken);
endinterface

// ===== rtl/edoc_refresh_timer.sv
`timescale 1ns/100ps
`include "edoc_defines.svh"
module edoc_refresh_timer #(
  parameter int INTERVAL = `EDOC_REFRESH_INTERVAL_CYC,
  parameter int BACKLOG_MAX = 8
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Refresh request
  edoc_tick_if.timer tick
);
  import edoc_pkg::*;
  logic [15:0] tick_reg, tick_next;
  logic [3:0] owed_reg, owed_next;
  logic lost_reg, lost_next;

  always_comb
  begin
    tick_next = tick_reg + 16'h0001;
    owed_next = owed_reg;
    lost_next = lost_reg;
    if (tick.taken && owed_next != 4'h0)
    begin
      owed_next = owed_next - 4'h1;
    end
    if (tick_reg == 16'(INTERVAL - 1))
    begin
      tick_next = 16'h0000;
      if (owed_reg == 4'(BACKLOG_MAX))
      begin
        lost_next = 1'b1;
      end
      else
      begin
        owed_next = owed_next + 4'h1;
      end
    end
    if (tick.taken && owed_reg == 4'h0)
    begin
      lost_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_reg <= 16'h0000;
      owed_reg <= 4'h0;
      lost_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
      owed_reg <= owed_next;
      lost_reg <= lost_next;
    end
  end

  assign tick.due = owed_reg != 4'h0;
  assign tick.wakeNeeded = lost_reg;
endmodule

// ===== rtl/edoc_controller.sv
`timescale 1ns/100ps
`include "edoc_defines.svh"
module edoc_controller #(
  parameter int ROW_BITS = 13,
  parameter int COL_BITS = 11,
  parameter int ADDR_BITS = 13,
  parameter int DATA_BITS = 4,
  parameter int INIT_PAUSE = `EDOC_INIT_PAUSE_CYC,
  parameter int PAGE_MAX = `EDOC_PAGE_MAX_CYC,
  parameter int REFRESH_INTERVAL = `EDOC_REFRESH_INTERVAL_CYC
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // User request
  input wire logic reqValid,
  input wire edoc_pkg::edoc_op_e reqOp,
  input wire logic [ROW_BITS-1:0] reqRow,
  input wire logic [COL_BITS-1:0] reqCol,
  input wire logic [DATA_BITS-1:0] reqData,
  output logic reqReady,
  output logic [DATA_BITS-1:0] rdData,
  output logic rdValid,
  output logic initDone,
  // DRAM pins
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeEnable_n,
  output logic outputEnable_n,
  output logic [ADDR_BITS-1:0] addr,
  input wire logic [DATA_BITS-1:0] dqIn,
  output logic [DATA_BITS-1:0] dqOut,
  output logic dqOe_n
);
  import edoc_pkg::*;

  localparam int RC = `EDOC_CYC_MIN(`EDOC_RANDOM_CYCLE_NS);
  localparam int RAS_MIN = `EDOC_CYC_MIN(`EDOC_RAS_MIN_NS);
  localparam int RP = `EDOC_CYC_MIN(`EDOC_RAS_PRECHARGE_NS);
  localparam int RCD = `EDOC_CYC_MIN(`EDOC_RAS_TO_CAS_NS);
  localparam int CAS_W = `EDOC_CYC_MIN(`EDOC_CAS_MIN_NS);
  localparam int CP = `EDOC_CYC_MIN(`EDOC_CAS_PRECHARGE_NS);
  localparam int PC = `EDOC_CYC_MIN(`EDOC_PAGE_CYCLE_NS);
  localparam int CSR = `EDOC_CYC_MIN(`EDOC_REFRESH_COLUMN_SETUP_NS);
  localparam int CHR = `EDOC_CYC_MIN(`EDOC_REFRESH_COLUMN_HOLD_NS);
  localparam int WPZ = `EDOC_CYC_MIN(`EDOC_WRITE_DISABLE_PULSE_NS);
  // First page count at which a column hit is refused, so the page closes within the width limit
  localparam int HIT_LIMIT = PAGE_MAX - 2 * (CAS_W + WPZ + PC + RP);

  typedef enum logic [3:0] {
    EDOC_PAUSE, EDOC_IDLE, EDOC_ROW, EDOC_COL, EDOC_PAGE, EDOC_PRECHARGE,
    EDOC_REF_CAS, EDOC_REF_RAS, EDOC_REF_END, EDOC_WPZ
  } edoc_state_e;

  edoc_tick_if tick();

  edoc_refresh_timer #(
    .INTERVAL(REFRESH_INTERVAL),
    .BACKLOG_MAX(8)
  ) timer (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  edoc_state_e state_reg, state_next;
  logic [31:0] wait_reg, wait_next;
  logic [31:0] page_reg, page_next;
  logic [31:0] rc_reg, rc_next;
  logic [3:0] wake_reg, wake_next;
  logic [ROW_BITS-1:0] openRow_reg, openRow_next;
  logic ras_reg, ras_next, cas_reg, cas_next, we_reg, we_next, oe_reg, oe_next;
  logic [ADDR_BITS-1:0] addr_reg, addr_next;
  logic [DATA_BITS-1:0] dq_reg, dq_next, rd_reg, rd_next;
  logic dqOe_reg, dqOe_next, rdv_reg, rdv_next, ready_reg, ready_next;
  logic isWrite_reg, isWrite_next, done_reg, done_next;
  logic pend_reg, pend_next;

  function automatic logic [31:0] lastCyc(input int n);
    lastCyc = (n < 1) ? 32'h0 : 32'(n - 1);
  endfunction

  always_comb
  begin
    state_next = state_reg;
    wait_next = (wait_reg != 32'h0) ? wait_reg - 32'h1 : 32'h0;
    page_next = ras_reg ? 32'h0 : page_reg + 32'h1;
    rc_next = (rc_reg != 32'h0) ? rc_reg - 32'h1 : 32'h0;
    wake_next = wake_reg;
    openRow_next = openRow_reg;
    ras_next = ras_reg;
    cas_next = cas_reg;
    we_next = we_reg;
    oe_next = oe_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    rd_next = rd_reg;
    dqOe_next = dqOe_reg;
    rdv_next = 1'b0;
    ready_next = 1'b0;
    isWrite_next = isWrite_reg;
    done_next = done_reg;
    pend_next = pend_reg;
    tick.taken = 1'b0;
    // A request seen with ready is kept until its access starts
    if (reqValid && reqReady)
    begin
      pend_next = 1'b1;
    end
    unique case (state_reg)
      EDOC_PAUSE:
      begin
        if (wait_reg == 32'h0)
        begin
          state_next = EDOC_REF_CAS;
          we_next = 1'b1;
          cas_next = 1'b0;
          wait_next = lastCyc(CSR);
        end
      end
      EDOC_IDLE, EDOC_PAGE:
      begin
        if (state_reg == EDOC_PAGE && (tick.due || tick.wakeNeeded
            || page_reg >= 32'(PAGE_MAX - PC - RP)))
        begin
          state_next = EDOC_PRECHARGE;
          ras_next = 1'b1;
          oe_next = 1'b1;
          wait_next = lastCyc(RP);
        end
        else if (state_reg == EDOC_IDLE && (tick.due || tick.wakeNeeded)
                 && rc_reg == 32'h0 && wait_reg == 32'h0)
        begin
          if (tick.wakeNeeded)
          begin
            wake_next = 4'(`EDOC_WAKE_CYCLES);
          end
          state_next = EDOC_REF_CAS;
          cas_next = 1'b0;
          we_next = 1'b1;
          wait_next = lastCyc(CSR);
        end
        else if (pend_reg && wait_reg == 32'h0)
        begin
          isWrite_next = reqOp == EDOC_OP_WRITE;
          if (state_reg == EDOC_PAGE && reqRow == openRow_reg
              && reqOp != EDOC_OP_REFRESH_ROW && page_reg < 32'(HIT_LIMIT))
          begin
            state_next = EDOC_COL;
            pend_next = 1'b0;
            addr_next = ADDR_BITS'(reqCol);
            cas_next = 1'b0;
            we_next = reqOp != EDOC_OP_WRITE;
            oe_next = reqOp == EDOC_OP_WRITE;
            dq_next = reqData;
            dqOe_next = reqOp != EDOC_OP_WRITE;
            wait_next = lastCyc(CAS_W);
          end
          else if (state_reg == EDOC_PAGE)
          begin
            state_next = EDOC_PRECHARGE;
            ras_next = 1'b1;
            oe_next = 1'b1;
            wait_next = lastCyc(RP);
          end
          else if (rc_reg == 32'h0)
          begin
            state_next = EDOC_ROW;
            pend_next = 1'b0;
            addr_next = ADDR_BITS'(reqRow);
            openRow_next = reqRow;
            ras_next = 1'b0;
            we_next = 1'b1;
            rc_next = lastCyc(RC);
            wait_next = lastCyc(RCD);
            if (reqOp == EDOC_OP_REFRESH_ROW)
            begin
              wait_next = lastCyc(RAS_MIN);
            end
          end
        end
      end
      EDOC_ROW:
      begin
        if (wait_reg == 32'h0)
        begin
          state_next = EDOC_COL;
          addr_next = ADDR_BITS'(reqCol);
          cas_next = 1'b0;
          we_next = !isWrite_reg;
          oe_next = isWrite_reg;
          dq_next = reqData;
          dqOe_next = !isWrite_reg;
          wait_next = lastCyc(CAS_W);
          if (reqOp == EDOC_OP_REFRESH_ROW)
          begin
            state_next = EDOC_PRECHARGE;
            cas_next = 1'b1;
            oe_next = 1'b1;
            ras_next = 1'b1;
            wait_next = lastCyc(RP);
          end
        end
      end
      EDOC_COL:
      begin
        if (wait_reg == 32'h0)
        begin
          state_next = EDOC_PAGE;
          cas_next = 1'b1;
          we_next = 1'b1;
          dqOe_next = 1'b1;
          rd_next = dqIn;
          rdv_next = !isWrite_reg;
          wait_next = lastCyc(PC - CAS_W);
          if (isWrite_reg)
          begin
            state_next = EDOC_WPZ;
          end
        end
      end
      EDOC_WPZ:
      begin
        we_next = 1'b0;
        oe_next = 1'b1;
        if (wait_reg == 32'h0 && we_reg == 1'b0)
        begin
          state_next = EDOC_PAGE;
          we_next = 1'b1;
        end
        else if (we_reg)
        begin
          wait_next = lastCyc(WPZ);
        end
      end
      EDOC_PRECHARGE:
      begin
        cas_next = 1'b1;
        if (wait_reg == 32'h0)
        begin
          state_next = EDOC_IDLE;
        end
      end
      EDOC_REF_CAS:
      begin
        if (wait_reg == 32'h0)
        begin
          state_next = EDOC_REF_RAS;
          ras_next = 1'b0;
          wait_next = lastCyc(RAS_MIN > CHR ? RAS_MIN : CHR);
          rc_next = lastCyc(RC);
        end
      end
      EDOC_REF_RAS:
      begin
        if (wait_reg == 32'h0)
        begin
          state_next = EDOC_REF_END;
          ras_next = 1'b1;
          cas_next = 1'b1;
          tick.taken = 1'b1;
          wait_next = lastCyc(RP);
        end
      end
      EDOC_REF_END:
      begin
        if (wait_reg == 32'h0 && rc_reg == 32'h0)
        begin
          state_next = EDOC_IDLE;
          if (wake_reg > 4'h1)
          begin
            wake_next = wake_reg - 4'h1;
            state_next = EDOC_REF_CAS;
            cas_next = 1'b0;
            wait_next = lastCyc(CSR);
          end
          else
          begin
            wake_next = 4'h0;
            done_next = 1'b1;
          end
        end
      end
      default:
      begin
        state_next = EDOC_IDLE;
      end
    endcase
    // Ready only when the next cycle is idle or open page with nothing held
    ready_next = done_next && !tick.due && !tick.wakeNeeded && !pend_next
                 && (state_next == EDOC_IDLE || state_next == EDOC_PAGE);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= EDOC_PAUSE;
      wait_reg <= 32'(INIT_PAUSE - 1);
      page_reg <= 32'h0;
      rc_reg <= 32'h0;
      wake_reg <= 4'h8;
      openRow_reg <= '0;
      ras_reg <= 1'b1;
      cas_reg <= 1'b1;
      we_reg <= 1'b1;
      oe_reg <= 1'b1;
      addr_reg <= '0;
      dq_reg <= '0;
      rd_reg <= '0;
      dqOe_reg <= 1'b1;
      rdv_reg <= 1'b0;
      ready_reg <= 1'b0;
      isWrite_reg <= 1'b0;
      done_reg <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      page_reg <= page_next;
      rc_reg <= rc_next;
      wake_reg <= wake_next;
      openRow_reg <= openRow_next;
      ras_reg <= ras_next;
      cas_reg <= cas_next;
      we_reg <= we_next;
      oe_reg <= oe_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      rd_reg <= rd_next;
      dqOe_reg <= dqOe_next;
      rdv_reg <= rdv_next;
      ready_reg <= ready_next;
      isWrite_reg <= isWrite_next;
      done_reg <= done_next;
      pend_reg <= pend_next;
    end
  end

  assign reqReady = ready_reg;
  assign rdData = rd_reg;
  assign rdValid = rdv_reg;
  assign initDone = done_reg;
  assign rowStrobe_n = ras_reg;
  assign colStrobe_n = cas_reg;
  assign writeEnable_n = we_reg;
  assign outputEnable_n = oe_reg;
  assign addr = addr_reg;
  assign dqOut = dq_reg;
  assign dqOe_n = dqOe_reg;
endmodule

// ===== tb/edoc_assertions.sv
`timescale 1ns/100ps
module edoc_assertions #(
  parameter int PAGE_MAX = 200
)(
  // Clock and reset
  clock,
  rst_n,
  // User side
  reqReady,
  rdValid,
  initDone,
  // Memory pins
  rowStrobe_n,
  colStrobe_n,
  writeEnable_n,
  outputEnable_n,
  dqOe_n
);
  input wire logic clock;
  input wire logic rst_n;
  input wire logic reqReady;
  input wire logic rdValid;
  input wire logic initDone;
  input wire logic rowStrobe_n;
  input wire logic colStrobe_n;
  input wire logic writeEnable_n;
  input wire logic outputEnable_n;
  input wire logic dqOe_n;
  int rasLow_reg;
  int rasLow_next;
  logic [3:0] wakeCnt_reg;
  logic [3:0] wakeCnt_next;
  logic rasPrev_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Row strobe low time and refresh count
  always_comb
  begin
    rasLow_next = rowStrobe_n ? 0 : rasLow_reg + 1;
    wakeCnt_next = wakeCnt_reg;
    if (rasPrev_reg && !rowStrobe_n && !colStrobe_n && wakeCnt_reg != 4'hF)
      wakeCnt_next = wakeCnt_reg + 4'h1;
  end
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      rasLow_reg <= 0;
      wakeCnt_reg <= 4'h0;
      rasPrev_reg <= 1'b1;
    end
    else
    begin
      rasLow_reg <= rasLow_next;
      wakeCnt_reg <= wakeCnt_next;
      rasPrev_reg <= rowStrobe_n;
    end
  chk_row_before_col: assert property (
    $fell(colStrobe_n) && !rowStrobe_n |-> !$past(rowStrobe_n))
    else $error("column strobe fell in the cycle the row opened");
  chk_refresh_row_follows: assert property (
    $fell(colStrobe_n) && rowStrobe_n |-> ##[1:4] !rowStrobe_n)
    else $error("column strobe fell with no row open");
  chk_refresh_col_setup: assert property (
    $fell(rowStrobe_n) && !colStrobe_n |-> !$past(colStrobe_n) ##1 !colStrobe_n)
    else $error("column strobe setup or hold short in refresh");
  chk_refresh_write_high: assert property (
    $fell(rowStrobe_n) && !colStrobe_n |-> writeEnable_n && $past(writeEnable_n)
      ##1 writeEnable_n)
    else $error("write enable not high around refresh");
  chk_ras_cycle_time: assert property (
    $fell(rowStrobe_n) |=> !$fell(rowStrobe_n) [*2])
    else $error("row strobe cycles too close");
  chk_page_width: assert property (rasLow_reg <= PAGE_MAX)
    else $error("row strobe held low too long");
  chk_no_bus_fight: assert property (!dqOe_n |-> outputEnable_n)
    else $error("data driven while output enable low");
  chk_early_write: assert property (
    $fell(colStrobe_n) && !dqOe_n |-> !writeEnable_n)
    else $error("write data without early write enable");
  chk_read_enabled: assert property (
    rdValid |-> $past(writeEnable_n) && !$past(outputEnable_n))
    else $error("read data taken without output enable");
  chk_wake_count: assert property ($rose(initDone) |-> wakeCnt_reg >= 4'h8)
    else $error("init done before eight wake refreshes");
  chk_ready_after_init: assert property (reqReady |-> initDone)
    else $error("request accepted before init done");
  cov_read: cover property (rdValid);
  cov_refresh: cover property ($fell(rowStrobe_n) && !colStrobe_n);
  cov_write: cover property ($fell(colStrobe_n) && !writeEnable_n);
endmodule
bind edoc_controller edoc_assertions #(.PAGE_MAX(PAGE_MAX)) u_chk (
  .clock, .rst_n, .reqReady, .rdValid, .initDone, .rowStrobe_n, .colStrobe_n,
  .writeEnable_n, .outputEnable_n, .dqOe_n
);

// ===== tb/edoc_dram_model.sv
`timescale 1ns/100ps
module edoc_dram_model (
  // Strobes and enables
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  // Address and data
  input wire logic [12:0] addr,
  input wire logic [3:0] dqOut,
  output logic [3:0] dq
);
  logic [3:0] mem [logic [23:0]];
  logic [12:0] row = 13'h0000;
  logic [3:0] last = 4'h0;
  logic drive = 1'b0;
  int refreshCycles = 0;
  int rowsRefreshed = 0;
  // Sample just after each falling strobe edge so pins changed on that edge have settled
  always @(negedge rowStrobe_n)
  begin
    #1;
    if (colStrobe_n)
      row = addr;
    else
    begin
      refreshCycles++;
      rowsRefreshed += 2;
    end
  end
  always @(negedge colStrobe_n)
  begin
    #1;
    if (!rowStrobe_n && !writeEnable_n)
    begin
      mem[{row, addr[10:0]}] = dqOut;
      drive = 1'b0;
    end
    else if (!rowStrobe_n)
    begin
      last = mem.exists({row, addr[10:0]}) ? mem[{row, addr[10:0]}] : 4'h0;
      drive = 1'b1;
    end
  end
  always @(posedge rowStrobe_n or posedge colStrobe_n)
    if (rowStrobe_n && colStrobe_n)
      drive = 1'b0;
  always @(negedge writeEnable_n)
    drive = 1'b0;
  always @(posedge outputEnable_n)
    if (colStrobe_n)
      drive = 1'b0;
  // Released lines show the inverse of the last value
  assign dq = (drive && !outputEnable_n) ? last : ~last;
endmodule

// ===== tb/edo_dram_access_refresh_test.sv
`timescale 1ns/100ps
module edo_dram_access_refresh_test;
  import edoc_pkg::*;
  typedef struct {edoc_op_e op; logic [12:0] row; logic [10:0] col; logic [3:0] d;
    logic [3:0] exp;} edoc_vec_s;
  localparam int INTERVAL = 50;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  edoc_op_e reqOp = EDOC_OP_READ;
  logic [12:0] reqRow = 13'h0000;
  logic [10:0] reqCol = 11'h000;
  logic [3:0] reqData = 4'h0;
  logic reqReady, rdValid, initDone, rowStrobe_n, colStrobe_n;
  logic writeEnable_n, outputEnable_n, dqOe_n;
  logic [3:0] rdData, dqOut;
  logic [12:0] addr;
  wire logic [3:0] dqBus;
  int errorCnt = 0;
  int totalChecks = 0;
  int base;
  edoc_vec_s vecs [9] = '{
    '{EDOC_OP_WRITE, 13'h0005, 11'h003, 4'hA, 4'h0},
    '{EDOC_OP_WRITE, 13'h0005, 11'h004, 4'h5, 4'h0},
    '{EDOC_OP_READ, 13'h0005, 11'h003, 4'h0, 4'hA},
    '{EDOC_OP_READ, 13'h0005, 11'h004, 4'h0, 4'h5},
    '{EDOC_OP_WRITE, 13'h1FFF, 11'h7FF, 4'hF, 4'h0},
    '{EDOC_OP_READ, 13'h0005, 11'h003, 4'h0, 4'hA},
    '{EDOC_OP_READ, 13'h1FFF, 11'h7FF, 4'h0, 4'hF},
    '{EDOC_OP_REFRESH_ROW, 13'h0009, 11'h000, 4'h0, 4'h9},
    '{EDOC_OP_READ, 13'h0000, 11'h000, 4'h0, 4'h0}};
  always #25 clock = ~clock;
  edoc_controller #(.INIT_PAUSE(20), .PAGE_MAX(200), .REFRESH_INTERVAL(INTERVAL)) u_dut (
    .clock, .rst_n, .reqValid, .reqOp, .reqRow, .reqCol, .reqData, .reqReady, .rdData,
    .rdValid, .initDone, .rowStrobe_n, .colStrobe_n, .writeEnable_n, .outputEnable_n,
    .addr, .dqIn(dqBus), .dqOut, .dqOe_n);
  edoc_dram_model u_mem (.rowStrobe_n, .colStrobe_n, .writeEnable_n, .outputEnable_n,
    .addr, .dqOut, .dq(dqBus));
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic waitFor(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 4000)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000)
    begin
      errorCnt++;
      results();
    end
  endtask
  task automatic runOp(input edoc_vec_s v);
    @(posedge clock);
    reqOp <= v.op;
    {reqRow, reqCol, reqData} <= {v.row, v.col, v.d};
    reqValid <= 1'b1;
    @(negedge clock);
    waitFor(reqReady);
    @(posedge clock);
    reqValid <= 1'b0;
    @(negedge clock);
    if (v.op == EDOC_OP_READ)
    begin
      waitFor(rdValid);
      check("read data", v.exp, rdData);
    end
    else
    begin
      waitFor(reqReady);
    end
  endtask
  task automatic pinsInReset();
    @(negedge clock);
    check("pins in reset", 4'hE, {rowStrobe_n, colStrobe_n, dqOe_n, reqReady});
  endtask
  task automatic awaitInit(input int from);
    waitFor(initDone);
    check("wake refreshes", 4'h1, {3'h0, u_mem.refreshCycles - from >= 8});
    $display("init test done");
  endtask
  initial
  begin
    pinsInReset();
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    awaitInit(0);
    foreach (vecs[i])
    begin
      runOp(vecs[i]);
      if (vecs[i].op == EDOC_OP_REFRESH_ROW)
      begin
        @(negedge clock);
        check("refreshed row", vecs[i].exp, u_mem.row[3:0]);
      end
    end
    $display("table test done");
    base = u_mem.refreshCycles;
    repeat (10 * INTERVAL) @(negedge clock);
    check("refresh rate", 4'h1, {3'h0, u_mem.refreshCycles - base >= 9});
    runOp(vecs[3]);
    $display("refresh test done");
    @(posedge clock);
    rst_n <= 1'b0;
    pinsInReset();
    @(posedge clock);
    rst_n <= 1'b1;
    awaitInit(u_mem.refreshCycles);
    runOp(vecs[2]);
    $display("second reset test done");
    results();
  end
endmodule
